/* File: design/ext_interrupt_pin_latch.sv */
// external interrupt pin latch with mask, level mode, acknowledge and apb registers
// Functional notes
// RL1 - falling edge on the pin sets the request latch in both modes
// RL2 - vector fetch produces an acknowledge clearing the latch
// RL3 - writing one to the acknowledge bit clears the latch like a fetch
// RL4 - reset clears the request latch unconditionally
// RL5 - edge-only after reset; mode bit selects edge or edge plus low level
// RL6 - mask bit at one blocks the request; zero lets it through
// RL7 - cpu global interrupt mask also blocks this request
// RL8 - mode one triggers on falling edges and on sustained low level
// RL9 - in level mode request stays while pin is low despite acknowledges
// RL10 - level mode clears only after pin high and acknowledge, any order
// RL11 - falling edge after an acknowledge write latches a fresh request
// RL12 - reset also clears mode bit, removing request with pin still low
// RL13 - in edge mode an acknowledge clears the latch at once
// RL14 - pending flag shows latch state regardless of the mask
// RL15 - acknowledge bit is write-only and reads zero
// RL16 - block works in wait; unmasked request wakes the processor
// RL17 - block works in stop; detection needs no bus clock (here detection runs on the bus clock i_clk)
// RL18 - in break with clear enable one, acknowledge writes clear the latch
// RL19 - in break with clear enable zero, accesses leave pending status alone
// RL20 - fetch after unmasked request loads this block's vector
// RL21 - software in level mode should mask inside the service routine
// RL22 - pin acts as interrupt input only when the pin enable bit is one
// RL23 - pin is synchronised to the bus clock before edge detection
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module ext_interrupt_pin_latch
  import ext_irq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_irq_pin_n,
  input wire logic i_vector_fetch,
  input wire logic i_cpu_int_mask,
  input wire logic i_break_state,
  output logic o_irq_request,
  output logic o_wakeup,
  output logic o_vector_select,
  output logic o_pin_level
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic pin_level;
  logic pin_level_q;
  logic request_latch;
  logic mode_level;
  logic request_mask;
  logic pin_function_enable;
  logic break_clear_enable;
  logic wr_status;
  logic wr_system;
  logic rd_hit;
  logic access;
  logic falling_edge;
  logic low_level;
  logic soft_ack;
  logic any_ack;
  logic pending;
  logic next_request_latch;

  // merge the pending view: latch or, in level mode, a low pin
  function automatic logic pend_of(input logic latch, input logic lvl_mode, input logic low);
    pend_of = latch || (lvl_mode && low);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // submodules
  pin_sync u_sync
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_irq_pin_n),
    .o_level(pin_level) // RL23
  );

  apb_regs_slave u_apb
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .o_wr_status(wr_status),
    .o_wr_system(wr_system),
    .o_rd_hit(rd_hit),
    .o_access(access)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the filtered pin level
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_level_q <= 1'b1;
    end
    else
    begin
      pin_level_q <= pin_level;
    end
  end

  // a disabled pin serves its general-purpose role and raises nothing
  always_comb
  begin
    falling_edge = pin_function_enable && pin_level_q && !pin_level; // RL22
    low_level = pin_function_enable && !pin_level; // RL22
    // acknowledge writes are shielded during break unless clear is enabled
    soft_ack = wr_status && i_pwdata[ACK_BIT] && (!i_break_state || break_clear_enable); // RL3 RL18 RL19
    any_ack = soft_ack || i_vector_fetch; // RL2
    pending = pend_of(request_latch, mode_level, low_level); // RL9 RL10
  end

  ////////////////////////////////////////////////////////////////////////////
  // request latch: a set in the same cycle as an acknowledge wins
  always_comb
  begin
    next_request_latch = request_latch;
    if (any_ack)
    begin
      next_request_latch = 1'b0; // RL13
    end
    if (falling_edge)
    begin
      next_request_latch = 1'b1; // RL1 RL11
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      request_latch <= 1'b0; // RL4
    end
    else
    begin
      request_latch <= next_request_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits in ext_int_status_control
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mode_level <= RESET_MODE; // RL5 RL12
      request_mask <= RESET_MASK;
    end
    else if (wr_status)
    begin
      mode_level <= i_pwdata[MODE_BIT]; // RL5 RL8
      request_mask <= i_pwdata[MASK_BIT];
    end
  end

  // system-level control: pin function enable and break clear enable
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_function_enable <= RESET_PIN_ENABLE;
      break_clear_enable <= RESET_BREAK_CLEAR;
    end
    else if (wr_system)
    begin
      pin_function_enable <= i_pwdata[PIN_ENABLE_BIT]; // RL22
      break_clear_enable <= i_pwdata[BREAK_CLEAR_BIT]; // RL18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the cpu: request, wake and vector select
  // the latch updates in the same clock as the rest; a stop mode that gates
  // the bus clock must keep this clock running for detection to continue
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_irq_request <= 1'b0;
      o_wakeup <= 1'b0;
      o_vector_select <= 1'b0;
      o_pin_level <= 1'b1;
    end
    else
    begin
      o_irq_request <= pend_of(next_request_latch, mode_level, low_level) && !request_mask && !i_cpu_int_mask; // RL6 RL7
      o_wakeup <= pend_of(next_request_latch, mode_level, low_level) && !request_mask; // RL16 RL17
      o_vector_select <= pend_of(next_request_latch, mode_level, low_level) && !request_mask; // RL20
      o_pin_level <= pin_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read data and response
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_prdata <= 32'h00000000;
    end
    else if (i_psel && !i_penable && !i_pwrite)
    begin
      o_prdata <= 32'h00000000;
      if (i_paddr == STATUS_CONTROL_OFFSET)
      begin
        o_prdata[FLAG_BIT] <= pending; // RL14
        o_prdata[MASK_BIT] <= request_mask;
        o_prdata[MODE_BIT] <= mode_level;
        o_prdata[ACK_BIT] <= 1'b0; // RL15
      end
      else if (i_paddr == SYSTEM_CONTROL_OFFSET)
      begin
        o_prdata[PIN_ENABLE_BIT] <= pin_function_enable;
        o_prdata[BREAK_CLEAR_BIT] <= break_clear_enable;
      end
    end
  end

  // unmapped addresses end with an error; ready is always given
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pready <= 1'b1;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= 1'b1;
      o_pslverr <= i_psel && !i_penable && !rd_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence ack_seen;
    any_ack && !falling_edge;
  endsequence

  chk_edge_sets_latch: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL1
    falling_edge |=> request_latch)
    else $error("falling edge did not set latch");
  chk_ack_clears_edge: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL13
    ack_seen |=> !request_latch)
    else $error("acknowledge did not clear latch");
  chk_level_holds: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL9
    (mode_level && low_level && !request_mask && !i_cpu_int_mask && !wr_status) |=> o_irq_request)
    else $error("level request dropped while pin low");
  chk_mask_blocks: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL6
    request_mask && !wr_status |=> !o_irq_request)
    else $error("masked request reached cpu");
  chk_cpu_mask: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL7
    i_cpu_int_mask |=> !o_irq_request)
    else $error("cpu mask ignored");
  chk_break_protect: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL19
    (i_break_state && !break_clear_enable && request_latch && !i_vector_fetch) |=> request_latch)
    else $error("break access changed pending status");
  chk_disabled_pin: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL22
    !pin_function_enable && !request_latch |=> !request_latch)
    else $error("disabled pin set the latch");
  chk_flag_unmasked: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL14
    (i_psel && !i_penable && !i_pwrite && i_paddr == STATUS_CONTROL_OFFSET) |=> o_prdata[FLAG_BIT] == $past(pending) && !o_prdata[ACK_BIT])
    else $error("pending flag read wrong");

  ////////////////////////////////////////////////////////////////////////////
  // clear paths: each acknowledge source on its own, with no edge racing it
  // set wins over a coincident acknowledge, so the edge is excluded here
  sequence free_ack_write;
    wr_status && i_pwdata[ACK_BIT] && !i_break_state && !falling_edge;
  endsequence

  sequence break_ack_write;
    wr_status && i_pwdata[ACK_BIT] && i_break_state && break_clear_enable && !falling_edge;
  endsequence

  // a set latch that nothing acknowledges in this cycle
  sequence latch_held;
    request_latch && !any_ack;
  endsequence

  chk_fetch_clears: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL2
    i_vector_fetch && !falling_edge |=> !request_latch)
    else $error("vector fetch did not clear latch");
  chk_soft_ack: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL3
    free_ack_write |=> !request_latch)
    else $error("acknowledge write did not clear latch");
  chk_break_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL18
    break_ack_write |=> !request_latch)
    else $error("enabled break clear did not clear latch");
  chk_latch_kept: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL10
    latch_held |=> request_latch)
    else $error("latch cleared without acknowledge");
  chk_fetch_edge_mode: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL13
    !mode_level && i_vector_fetch && !falling_edge && !wr_status |=> !pending)
    else $error("edge mode fetch left request pending");

  ////////////////////////////////////////////////////////////////////////////
  // outputs towards the cpu are registered from the next latch value, so they change in the same clock as the latch
  chk_wake_unmasked: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL16
    request_latch && !any_ack && !request_mask |=> o_wakeup)
    else $error("unmasked request did not wake");
  chk_level_wakes: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL17
    mode_level && low_level && !request_mask |=> o_wakeup)
    else $error("low level did not wake");
  chk_wake_masked: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL6
    request_mask |=> !o_wakeup)
    else $error("masked request woke the processor");
  chk_vector_unmasked: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL20
    request_latch && !any_ack && !request_mask |=> o_vector_select)
    else $error("unmasked request gave no vector");
  chk_vector_masked: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL20
    request_mask |=> !o_vector_select)
    else $error("masked request selected the vector");

  ////////////////////////////////////////////////////////////////////////////
  // bus side: errors only on unmapped words, the acknowledge bit reads zero
  chk_error_unmapped: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    access && !rd_hit |-> o_pslverr)
    else $error("unmapped access gave no error");
  chk_error_mapped: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    access && rd_hit |-> !o_pslverr)
    else $error("mapped access gave an error");
  chk_ack_reads_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL15
    i_psel && !i_penable && !i_pwrite |=> !o_prdata[ACK_BIT])
    else $error("acknowledge bit read as one");
endmodule
`default_nettype wire

/* File: shared/ext_irq_pkg.sv */
// package: register map, field positions and reset values of the external interrupt latch block
package ext_irq_pkg;
  // register byte offsets on the apb window
  localparam logic [11:0] STATUS_CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] SYSTEM_CONTROL_OFFSET = 12'h004;
  // field positions in ext_int_status_control
  localparam int MODE_BIT = 0;
  localparam int MASK_BIT = 1;
  localparam int ACK_BIT = 2;
  localparam int FLAG_BIT = 3;
  // field positions in the system control register
  localparam int PIN_ENABLE_BIT = 0;
  localparam int BREAK_CLEAR_BIT = 1;
  // reset values
  localparam logic RESET_MODE = 1'b0;
  localparam logic RESET_MASK = 1'b0;
  localparam logic RESET_PIN_ENABLE = 1'b0;
  localparam logic RESET_BREAK_CLEAR = 1'b0;
  // synchroniser depth for the pin
  localparam int SYNC_STAGES = 3;
  // width of the register file bytes
  localparam int REG_WIDTH = 8;
endpackage

/* File: design/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import ext_irq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  output logic o_level
);
  logic [SYNC_STAGES-1:0] stage;

  // the pin idles high through its pullup, so the chain resets high
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stage <= '1;
    end
    else
    begin
      stage <= {stage[SYNC_STAGES-2:0], i_pin};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_level <= 1'b1;
    end
    else if (stage[1] == stage[2])
    begin
      o_level <= stage[2];
    end
  end
endmodule
`default_nettype wire

/* File: design/apb_regs_slave.sv */
// apb slave front end: zero-wait handshake and address decode
`timescale 1ns/1ps
`default_nettype none
module apb_regs_slave
  import ext_irq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  output logic o_wr_status,
  output logic o_wr_system,
  output logic o_rd_hit,
  output logic o_access
);
  // access phase completes in one cycle, so pready is a constant high at the top
  always_comb
  begin
    o_access = i_psel && i_penable;
    o_wr_status = o_access && i_pwrite && (i_paddr == STATUS_CONTROL_OFFSET);
    o_wr_system = o_access && i_pwrite && (i_paddr == SYSTEM_CONTROL_OFFSET);
    o_rd_hit = (i_paddr == STATUS_CONTROL_OFFSET) || (i_paddr == SYSTEM_CONTROL_OFFSET);
  end
endmodule
`default_nettype wire

/* File: tb/irq_source.sv */
// model of the external source that pulls the active-low interrupt pin
`timescale 1ns/1ps
`default_nettype none
module irq_source #(
  parameter int LAG = 3
) (
  input wire logic i_clk,
  input wire logic i_low_req,
  output logic o_pin_n
);
  int cnt = 0;
  ////////////////////////////////////////////////////////////////
  // a slow source lets go of the line LAG+1 cycles after it is asked to
  always_ff @(posedge i_clk)
  begin
    if (i_low_req)
      cnt <= LAG + 1;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // released line floats to the pull-up level, never holds the last value
  assign o_pin_n = (cnt > 0) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// directed testbench for the external interrupt pin latch
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ext_irq_pkg::*;
;
  localparam logic [11:0] ST = STATUS_CONTROL_OFFSET;
  localparam logic [11:0] SY = SYSTEM_CONTROL_OFFSET;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic fetch = 1'b0;
  logic cpu_mask = 1'b0;
  logic brk = 1'b0;
  logic low_req = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, pin_n, irq, wake, vsel, plev, er;
  int n_fail = 0;
  int tests_run = 0;
  ////////////////////////////////////////////////////////////////
  // free-running bus clock, 8 ns period
  initial
  begin
    forever #4 i_clk = ~i_clk;
  end
  irq_source #(.LAG(3)) u_src (.i_clk(i_clk), .i_low_req(low_req), .o_pin_n(pin_n));
  ext_interrupt_pin_latch u_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_irq_pin_n(pin_n),
    .i_vector_fetch(fetch), .i_cpu_int_mask(cpu_mask), .i_break_state(brk),
    .o_irq_request(irq), .o_wakeup(wake), .o_vector_select(vsel), .o_pin_level(plev));
  ////////////////////////////////////////////////////////////////
  task automatic final_report;
    begin
      if (n_fail == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      tests_run++;
      if (got !== exp)
      begin
        n_fail++;
        $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // one apb transfer; the request is held until pready is seen high
  // no cycle count is assumed; only the watchdog ends a wait
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    begin
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do
      begin
        @(posedge i_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    begin
      xfer(a, 1'b0, 32'h0);
      chk(nm, exp, rd);
    end
  endtask
  // pin changes need the synchroniser and edge register to settle
  task automatic pin(input logic lo);
    begin
      @(posedge i_clk);
      low_req <= lo;
      repeat (10) @(posedge i_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    final_report;
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rdchk(ST, 32'h0, "status reset");
    rdchk(SY, 32'h0, "system reset");
    pin(1'b1);
    pin(1'b0);
    rdchk(ST, 32'h0, "disabled pin");
    xfer(SY, 1'b1, 32'h1);
    pin(1'b1);
    chk("pin level", 32'h0, {31'h0, plev});
    pin(1'b0);
    chk("pin level high", 32'h1, {31'h0, plev});
    rdchk(ST, 32'h8, "edge latch");
    chk("request", 32'h1, {31'h0, irq});
    chk("wakeup", 32'h1, {31'h0, wake});
    chk("vector", 32'h1, {31'h0, vsel});
    xfer(ST, 1'b1, 32'h2);
    rdchk(ST, 32'ha, "masked flag");
    chk("masked request", 32'h0, {31'h0, irq});
    chk("masked wakeup", 32'h0, {31'h0, wake});
    xfer(ST, 1'b1, 32'h0);
    cpu_mask <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("cpu masked request", 32'h0, {31'h0, irq});
    chk("cpu masked wakeup", 32'h1, {31'h0, wake});
    cpu_mask <= 1'b0;
    xfer(ST, 1'b1, 32'h4);
    rdchk(ST, 32'h0, "ack clear");
    pin(1'b1);
    pin(1'b0);
    fetch <= 1'b1;
    @(posedge i_clk);
    fetch <= 1'b0;
    rdchk(ST, 32'h0, "fetch clear");
    pin(1'b1);
    xfer(ST, 1'b1, 32'h4);
    rdchk(ST, 32'h0, "edge ack pin low");
    xfer(ST, 1'b1, 32'h1);
    rdchk(ST, 32'h9, "level without edge");
    xfer(ST, 1'b1, 32'h0);
    pin(1'b0);
    pin(1'b1);
    rdchk(ST, 32'h8, "edge after ack");
    pin(1'b0);
    brk <= 1'b1;
    xfer(ST, 1'b1, 32'h4);
    rdchk(ST, 32'h8, "break protect");
    xfer(SY, 1'b1, 32'h3);
    xfer(ST, 1'b1, 32'h4);
    brk <= 1'b0;
    rdchk(ST, 32'h0, "break clear");
    xfer(ST, 1'b1, 32'h1);
    pin(1'b1);
    rdchk(ST, 32'h9, "level latch");
    xfer(ST, 1'b1, 32'h5);
    rdchk(ST, 32'h9, "level ack pin low");
    pin(1'b0);
    rdchk(ST, 32'h1, "level released");
    pin(1'b1);
    pin(1'b0);
    rdchk(ST, 32'h9, "level high first");
    xfer(ST, 1'b1, 32'h3);
    xfer(ST, 1'b1, 32'h7);
    rdchk(ST, 32'h3, "level ack after high");
    xfer(ST, 1'b1, 32'h1);
    pin(1'b1);
    i_reset_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rdchk(ST, 32'h0, "reset pin low");
    chk("reset request", 32'h0, {31'h0, irq});
    xfer(SY, 1'b1, 32'h1);
    rdchk(ST, 32'h0, "reset mode clear");
    chk("reset mode request", 32'h0, {31'h0, irq});
    pin(1'b0);
    xfer(12'h008, 1'b1, 32'hff);
    chk("unmapped error", 32'h1, {31'h0, er});
    final_report;
  end
endmodule
`default_nettype wire
